/* ubb_top.sv */
// ubb_top: serial side of a usb to async serial bridge.
// assumes host data arrives as byte streams and registers on a plain port.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// - divisor n in 2..16383 plus eighths
// - integer 1 gives 2M, 0 gives 3M
// - no fraction with integer 0 or 1
// - flush timeout 1..255 ms steps
// - bitbang turns control lines into port
// - bitbang bytes paced by prescaler
// - driver enable held through break outside bitbang
// - power enable gated by suspend, reset
// - optional weak pulldown while power off
// - 7/8 data, 1/2 stop, five parities
// - 384 byte rx, 128 byte tx buffers
// - hardware and xon/xoff flow control
// - event char and break detection
// - x16 oversample tick from reference
// - 14-bit integer plus 3 fraction bits
// - transmit enable drives rs485 driver
module ubb_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] host_tx_data,
	input wire logic host_tx_valid,
	output logic host_tx_ready,
	output logic [7:0] host_rx_data,
	output logic host_rx_valid,
	input wire logic host_rx_ready,
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic usb_reset,
	output logic txd,
	input wire logic rxd,
	output logic rts_n,
	input wire logic cts_n,
	output logic rs485_driver_enable,
	output logic [7:0] port_out,
	output logic [7:0] port_oe_n,
	input wire logic [7:0] port_in,
	output logic line_pulldown,
	output logic power_switch_enable_n,
	output logic irq
);
	////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [3:0] A_DIV = 4'h0; // [13:0] int, [16:14] frac
	localparam logic [3:0] A_FMT = 4'h1; // format and flow control
	localparam logic [3:0] A_FLUSH = 4'h2; // flush ms
	localparam logic [3:0] A_EVCH = 4'h3; // event character
	localparam logic [3:0] A_BB = 4'h4; // [0] bitbang, [15:8] dir
	localparam logic [3:0] A_STAT = 4'h5; // sticky events, w1c
	localparam logic [3:0] A_MASK = 4'h6; // interrupt mask
	localparam logic [3:0] A_LINE = 4'h7; // line state, read only

	logic [13:0] div_int_ff;
	logic [2:0] div_frac_ff;
	logic data7_ff; // seven data bits
	logic stop2_ff; // two stop bits
	logic [2:0] par_ff; // ubb_par_t encoding
	logic hwflow_ff; // rts/cts flow
	logic swflow_ff; // xon/xoff flow
	logic brk_ff; // send break
	logic pd_opt_ff; // pulldown option
	logic [7:0] flush_ms_ff;
	logic [7:0] evch_ff;
	logic bb_ff;
	logic [7:0] bb_dir_ff; // 1 = output
	logic [ubb_pkg::EV_W-1:0] stat_ff, mask_ff, ev;
	logic [7:0] rx_level_lo;

	////////////////////////////////////////////////////////////////////
	// submodules
	ubb_tick_if tk ();
	ubb_baud u_baud (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.div_int(div_int_ff),
		.div_frac(div_frac_ff),
		.t(tk.gen)
	);
	logic [7:0] txq_data;
	logic txq_valid, txq_ready;
	ubb_fifo #(.DEPTH(ubb_pkg::TX_DEPTH)) u_txq (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_data(host_tx_data),
		.in_valid(host_tx_valid),
		.in_ready(host_tx_ready),
		.out_data(txq_data),
		.out_valid(txq_valid),
		.out_ready(txq_ready),
		.level()
	);
	logic [7:0] rxq_in;
	logic rxq_push, rxq_room, rx_flush_ok;
	logic [$clog2(ubb_pkg::RX_DEPTH+1)-1:0] rx_level;
	logic rx_avail;
	ubb_fifo #(.DEPTH(ubb_pkg::RX_DEPTH)) u_rxq (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_data(rxq_in),
		.in_valid(rxq_push),
		.in_ready(rxq_room),
		.out_data(host_rx_data),
		.out_valid(rx_avail),
		.out_ready(host_rx_ready && rx_flush_ok),
		.level(rx_level)
	);
	assign host_rx_valid = rx_avail && rx_flush_ok;
	assign rx_level_lo = rx_level[7:0];

	////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_int_ff <= ubb_pkg::DIV_INT_RST;
			div_frac_ff <= ubb_pkg::DIV_FRAC_RST;
			{data7_ff, stop2_ff, par_ff, hwflow_ff} <= 6'h00;
			{swflow_ff, brk_ff, pd_opt_ff} <= 3'h0;
			flush_ms_ff <= ubb_pkg::FLUSH_MS_RST;
			evch_ff <= 8'h00;
			bb_ff <= 1'b0;
			bb_dir_ff <= 8'h00;
			mask_ff <= '0;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				A_DIV: begin
					div_int_ff <= reg_wdata[13:0];
					div_frac_ff <= reg_wdata[16:14];
				end
				A_FMT: begin
					data7_ff <= reg_wdata[0];
					stop2_ff <= reg_wdata[1];
					par_ff <= reg_wdata[4:2];
					hwflow_ff <= reg_wdata[5];
					swflow_ff <= reg_wdata[6];
					brk_ff <= reg_wdata[7];
					pd_opt_ff <= reg_wdata[8];
				end
				A_FLUSH: begin // zero is kept at one ms
					flush_ms_ff <= (reg_wdata[7:0] == 8'h00) ? 8'h01
						: reg_wdata[7:0];
				end
				A_EVCH: evch_ff <= reg_wdata[7:0];
				A_BB: begin
					bb_ff <= reg_wdata[0];
					bb_dir_ff <= reg_wdata[15:8];
				end
				A_MASK: mask_ff <= reg_wdata[ubb_pkg::EV_W-1:0];
				default: ;
			endcase
		end
	end

	// sticky status: a new event wins over a clearing write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			stat_ff <= '0;
		else if (clk_en)
			stat_ff <= (stat_ff & ~((reg_wr && reg_addr == A_STAT)
				? reg_wdata[ubb_pkg::EV_W-1:0] : '0)) | ev;
	end
	assign irq = |(stat_ff & mask_ff);

	// read port, data one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0;
		else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					A_DIV: reg_rdata <= {15'h0, div_frac_ff, div_int_ff};
					A_FMT: reg_rdata <= {23'h0, pd_opt_ff, brk_ff, swflow_ff,
						hwflow_ff, par_ff, stop2_ff, data7_ff};
					A_FLUSH: reg_rdata <= {24'h0, flush_ms_ff};
					A_EVCH: reg_rdata <= {24'h0, evch_ff};
					A_BB: reg_rdata <= {16'h0, bb_dir_ff, 7'h0, bb_ff};
					A_STAT: reg_rdata <= {28'h0, stat_ff};
					A_MASK: reg_rdata <= {28'h0, mask_ff};
					A_LINE: reg_rdata <= {16'h0, rx_level_lo, port_in};
					default: reg_rdata <= 32'h0;
				endcase
			end else
				reg_rdata <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmitter
	logic [3:0] tsub_ff; // oversample phase
	logic [3:0] tbit_ff; // bits left
	logic [11:0] tsh_ff; // frame shift register
	logic tbusy_ff;
	logic xoff_ff; // far end asked to stop
	logic par_bit;
	logic [3:0] frame_len;
	logic tx_go;
	// parity over the data bits that are sent
	always_comb begin
		case (par_ff)
			3'd1: par_bit = ~^(txq_data & {~data7_ff, 7'h7f});
			3'd2: par_bit = ^(txq_data & {~data7_ff, 7'h7f});
			3'd3: par_bit = 1'b1;
			default: par_bit = 1'b0;
		endcase
	end
	assign frame_len = 4'd8 - {3'h0, data7_ff} + {3'h0, par_ff != 3'd0}
		+ {3'h0, stop2_ff} + 4'd2;
	// flow control gates the start of a new frame
	assign tx_go = !bb_ff && !tbusy_ff && txq_valid && !brk_ff
		&& !(hwflow_ff && cts_n) && !(swflow_ff && xoff_ff);
	logic bb_take;
	assign txq_ready = tx_go || bb_take;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tsub_ff <= 4'h0;
			tbit_ff <= 4'h0;
			tsh_ff <= 12'hfff;
			tbusy_ff <= 1'b0;
		end else if (clk_en) begin
			if (tx_go) begin
				tsub_ff <= 4'h0;
				tbit_ff <= frame_len;
				tbusy_ff <= 1'b1;
				// stop ones, optional parity, data lsb first, start
				if (data7_ff)
					tsh_ff <= (par_ff != 3'd0) ? {2'b11, par_bit,
						txq_data[6:0], 1'b0, 1'b1} : {3'b111,
						txq_data[6:0], 1'b0, 1'b1};
				else
					tsh_ff <= (par_ff != 3'd0) ? {1'b1, par_bit,
						txq_data, 1'b0, 1'b1} : {2'b11, txq_data, 1'b0, 1'b1};
			end else if (tbusy_ff && tk.tick) begin
				tsub_ff <= tsub_ff + 4'h1;
				if (tsub_ff == 4'hf) begin
					tsh_ff <= {1'b1, tsh_ff[11:1]};
					tbit_ff <= tbit_ff - 4'h1;
					if (tbit_ff == 4'h1)
						tbusy_ff <= 1'b0;
				end
			end
		end
	end
	// break forces space and, outside port mode, keeps the driver on throughout
	assign txd = brk_ff ? 1'b0 : tsh_ff[1];
	assign rs485_driver_enable = !bb_ff && (tbusy_ff || brk_ff);

	////////////////////////////////////////////////////////////////////
	// receiver: simple mid-bit sampler on the oversample tick
	logic [3:0] rsub_ff, rbit_ff;
	logic [9:0] rsh_ff;
	logic rbusy_ff, rzero_ff;
	logic [3:0] rlen;
	logic rdone;
	assign rlen = 4'd8 - {3'h0, data7_ff} + {3'h0, par_ff != 3'd0} + 4'd1;
	// a frame frozen by a switch to port mode must not keep completing
	assign rdone = rbusy_ff && tk.tick && rsub_ff == 4'h7
		&& rbit_ff == rlen && !bb_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsub_ff <= 4'h0;
			rbit_ff <= 4'h0;
			rsh_ff <= 10'h0;
			rbusy_ff <= 1'b0;
			rzero_ff <= 1'b1;
		end else if (clk_en && tk.tick && !bb_ff) begin
			if (!rbusy_ff) begin
				if (!rxd) begin
					rbusy_ff <= 1'b1;
					rsub_ff <= 4'h0;
					rbit_ff <= 4'h0;
					rzero_ff <= 1'b1;
				end
			end else begin
				rsub_ff <= rsub_ff + 4'h1;
				if (rsub_ff == 4'h7) begin
					rsh_ff <= {rxd, rsh_ff[9:1]};
					rzero_ff <= rzero_ff & !rxd;
					rbit_ff <= rbit_ff + 4'h1;
					if (rbit_ff == rlen)
						rbusy_ff <= 1'b0;
				end
			end
		end
	end
	// assembled data and parity, read in the cycle the stop bit is sampled
	logic [7:0] rbyte;
	logic rpar, rbreak;
	always_comb begin
		// seven-bit frames hold one sample less, so data sits one higher
		if (par_ff != 3'd0)
			rbyte = data7_ff ? {1'b0, rsh_ff[8:2]} : rsh_ff[8:1];
		else
			rbyte = data7_ff ? {1'b0, rsh_ff[9:3]} : rsh_ff[9:2];
		// parity is always the newest sample before the stop bit
		rpar = rsh_ff[9];
	end
	// all-zero frame including stop is a line break
	assign rbreak = rdone && rzero_ff && !rxd;
	logic rx_is_flow;
	assign rx_is_flow = swflow_ff && (rbyte == ubb_pkg::XON_CHAR
		|| rbyte == ubb_pkg::XOFF_CHAR);
	assign rxq_in = bb_ff ? port_in : rbyte;
	assign rxq_push = bb_ff ? bb_take : (rdone && !rbreak && !rx_is_flow);
	// in-band flow characters steer the transmitter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			xoff_ff <= 1'b0;
		else if (clk_en && rdone && rx_is_flow && !rbreak)
			xoff_ff <= (rbyte == ubb_pkg::XOFF_CHAR);
	end
	// hardware handshake: ask to stop when rx buffer nears full
	assign rts_n = hwflow_ff ? (rx_level >= 9'(ubb_pkg::RX_DEPTH - 32))
		: 1'b0;

	// events: event char, break, flush, parity error
	logic flush_ev;
	logic par_bad;
	always_comb begin
		case (par_ff)
			3'd1: par_bad = rpar != ~^rbyte;
			3'd2: par_bad = rpar != ^rbyte;
			3'd3: par_bad = !rpar;
			3'd4: par_bad = rpar;
			default: par_bad = 1'b0;
		endcase
	end
	always_comb begin
		ev = '0;
		ev[ubb_pkg::EV_EVCHAR] = rdone && !rbreak && rbyte == evch_ff;
		ev[ubb_pkg::EV_BREAK] = rbreak;
		ev[ubb_pkg::EV_FLUSH] = flush_ev;
		ev[ubb_pkg::EV_PARERR] = rdone && !rbreak && par_bad;
	end

	////////////////////////////////////////////////////////////////////
	// flush timer: short packets go upstream on event char or timeout
	logic [$clog2(ubb_pkg::MS_CYC)-1:0] ms_cnt_ff;
	logic [7:0] ms_ff;
	logic release_ff;
	assign rx_flush_ok = release_ff || rx_level >= 9'd64;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_ff <= '0;
			ms_ff <= 8'h00;
			release_ff <= 1'b0;
			flush_ev <= 1'b0;
		end else if (clk_en) begin
			flush_ev <= 1'b0;
			if (rxq_push || !rx_avail) begin
				ms_cnt_ff <= '0;
				ms_ff <= 8'h00;
				if (!rx_avail)
					release_ff <= 1'b0;
				if (ev[ubb_pkg::EV_EVCHAR])
					release_ff <= 1'b1;
			end else if (!release_ff) begin
				if (ms_cnt_ff == ($clog2(ubb_pkg::MS_CYC))'(ubb_pkg::MS_CYC-1)) begin
					ms_cnt_ff <= '0;
					ms_ff <= ms_ff + 8'h01;
					if (ms_ff + 8'h01 >= flush_ms_ff) begin
						release_ff <= 1'b1;
						flush_ev <= 1'b1;
					end
				end else
					ms_cnt_ff <= ms_cnt_ff + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// bitbang: one byte per x16 tick, held between ticks
	logic [7:0] bb_out_ff;
	assign bb_take = bb_ff && tk.tick && txq_valid && rxq_room;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bb_out_ff <= 8'h00;
		else if (clk_en && bb_take)
			bb_out_ff <= txq_data;
	end
	// port lines: in bitbang, directions from software
	assign port_out = bb_ff ? bb_out_ff : 8'h00;
	assign port_oe_n = bb_ff ? ~bb_dir_ff : 8'hff;

	////////////////////////////////////////////////////////////////////
	// power enable gated on chip
	assign power_switch_enable_n = !(usb_configured && !usb_suspend
		&& !usb_reset);
	assign line_pulldown = pd_opt_ff && power_switch_enable_n;
endmodule

/* ubb_pkg.sv */
// ubb_pkg: constants shared by the usb-uart serial side block.
// assumes a 100 MHz ref_clk standing in for the 48 MHz baud reference.
package ubb_pkg;
	localparam int CLK_HZ = 100_000_000; // system clock rate
	localparam int REF_HZ = 48_000_000; // nominal baud reference
	localparam int MS_CYC = CLK_HZ / 1000; // cycles per millisecond
	localparam int OVS = 16; // oversampling factor
	localparam logic [13:0] DIV_INT_RST = 14'h0138; // 312: 9600 baud
	localparam logic [2:0] DIV_FRAC_RST = 3'h0;
	localparam logic [7:0] FLUSH_MS_RST = 8'h10; // 16 ms default
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	localparam int RX_DEPTH = 384; // upstream buffer bytes
	localparam int TX_DEPTH = 128; // downstream buffer bytes
	// fixed divides for integer settings 0 and 1 (reference cycles)
	localparam logic [13:0] DIV_ZERO_EQ = 14'h0001; // 3 Mbaud
	localparam logic [2:0] DIV_ONE_FRAC = 3'h4; // 1.5 -> 2 Mbaud
	// interrupt status bits
	localparam int EV_EVCHAR = 0;
	localparam int EV_BREAK = 1;
	localparam int EV_FLUSH = 2;
	localparam int EV_PARERR = 3;
	localparam int EV_W = 4;
	typedef enum logic [2:0] {UBB_PAR_NONE, UBB_PAR_ODD, UBB_PAR_EVEN,
		UBB_PAR_MARK, UBB_PAR_SPACE} ubb_par_t;
endpackage

/* ubb_tick_if.sv */
// ubb_tick_if: oversample tick between the baud generator and users.
// assumes one clock domain.
`timescale 1ns/100ps
interface ubb_tick_if;
	logic tick; // one-cycle x16 oversample pulse
	modport gen (output tick);
	modport use_ (input tick);
endinterface

/* ubb_baud.sv */
// ubb_baud: fractional prescaler producing the x16 oversample tick.
// assumes divisor fields are stable software settings.
`timescale 1ns/100ps
module ubb_baud (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [13:0] div_int,
	input wire logic [2:0] div_frac,
	ubb_tick_if.gen t
);
	// phase accumulator in eighths of a reference period, scaled to ref_clk
	logic [31:0] acc_ff;
	logic [31:0] step; // divisor in eighths
	logic [31:0] nxt_acc;
	logic [31:0] lim; // divisor scaled to the accumulator's units
	always_comb begin
		if (div_int == 14'h0000)
			step = {29'h0, 3'h0} + 32'(ubb_pkg::DIV_ZERO_EQ) * 32'd8;
		else if (div_int == 14'h0001)
			step = 32'd8 + 32'(ubb_pkg::DIV_ONE_FRAC);
		else
			step = {15'h0, div_int, div_frac};
		// each ref_clk adds 8*48/100 reference eighths; compare scaled
		nxt_acc = acc_ff + 32'd384;
		lim = step * 32'd100;
	end
	// tick when accumulated reference time reaches divisor
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= 32'h0;
			t.tick <= 1'b0;
		end else if (clk_en) begin
			if (nxt_acc >= lim) begin
				// a shorter divisor restarts the phase, no tick burst
				acc_ff <= (nxt_acc - lim >= lim) ? 32'h0 : nxt_acc - lim;
				t.tick <= 1'b1;
			end else begin
				acc_ff <= nxt_acc;
				t.tick <= 1'b0;
			end
		end
	end
endmodule

/* ubb_fifo.sv */
// ubb_fifo: byte buffer with valid/ready handshake on both sides.
// assumes one clock; depth need not be a power of two.
`timescale 1ns/100ps
module ubb_fifo #(
	parameter int DEPTH = 128
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [7:0] mem [DEPTH]; // storage array
	logic [AW-1:0] wp_ff, rp_ff;
	logic [$clog2(DEPTH+1)-1:0] cnt_ff;
	logic wr, rd;
	assign in_ready = (cnt_ff != ($clog2(DEPTH+1))'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem[rp_ff];
	assign level = cnt_ff;
	assign wr = in_valid && in_ready && clk_en;
	assign rd = out_valid && out_ready && clk_en;
	// storage write, no reset needed
	always_ff @(posedge ref_clk) begin
		if (wr)
			mem[wp_ff] <= in_data;
	end
	// pointers and count, wrapping at depth
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (wr)
				wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
			if (rd)
				rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
			if (wr && !rd)
				cnt_ff <= cnt_ff + 1'b1;
			else if (rd && !wr)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule

/* ubb_monitor.sv */
// ubb_monitor: port level checks on the serial side block.
// assumes one clock domain; bound to every ubb_top instance.
`timescale 1ns/100ps
module ubb_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic txd,
	input wire logic rs485_driver_enable,
	input wire logic [7:0] port_oe_n,
	input wire logic line_pulldown,
	input wire logic power_switch_enable_n,
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic usb_reset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// read data stands only in the cycle after a read
	property p_rdata_idle;
		clk_en && !$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	// settled usb state decides the power switch
	property p_pwr_off;
		(!usb_configured || usb_suspend || usb_reset) [*3]
			|-> power_switch_enable_n;
	endproperty
	a_pwr_off: assert property (p_pwr_off)
		else $error("power on while not allowed");
	property p_pwr_on;
		(usb_configured && !usb_suspend && !usb_reset) [*3]
			|-> !power_switch_enable_n;
	endproperty
	a_pwr_on: assert property (p_pwr_on)
		else $error("power off while configured");
	// pulldown may only bleed the lines while power is off
	property p_pd_gate;
		(!power_switch_enable_n) [*2] |-> !line_pulldown;
	endproperty
	a_pd_gate: assert property (p_pd_gate)
		else $error("pulldown with power on");
	// outside port mode, a low line (start, data or break) always has the driver on
	property p_de_low;
		(!txd) [*2] |-> rs485_driver_enable;
	endproperty
	a_de_low: assert property (p_de_low)
		else $error("driver off while line low");
	// driver is let go only with the line back at idle, unless port mode is entered mid frame
	property p_de_stop;
		$fell(rs485_driver_enable) |-> txd;
	endproperty
	a_de_stop: assert property (p_de_stop)
		else $error("driver dropped mid frame");
	// parallel port mode keeps the rs485 driver quiet
	property p_bb_no_de;
		(port_oe_n != 8'hff) [*2] |-> !rs485_driver_enable;
	endproperty
	a_bb_no_de: assert property (p_bb_no_de)
		else $error("driver on in port mode");
	// out of reset the pins are serial and idle
	property p_rst_idle;
		$rose(rst_n) |-> port_oe_n == 8'hff && txd;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("pins not idle after reset");
endmodule
bind ubb_top ubb_monitor u_mon (.*);

/* ubb_line_model.sv */
// ubb_line_model: far end of the serial line.
// assumes the bench picks loopback or an idle line.
`timescale 1ns/100ps
module ubb_line_model (
	input wire logic txd,
	input wire logic loop_en,
	output logic rxd
);
	// an unused line rests at mark through its pull-up
	assign rxd = loop_en ? txd : 1'h1;
endmodule

/* tb.sv */
// tb: self-checking bench for the serial side block.
// assumes a 100 MHz clock and the line model at the serial pins.
`timescale 1ns/100ps
module tb;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic clk_en = 1'h1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic [7:0] host_tx_data = 8'h00;
	logic host_tx_valid = 1'h0;
	logic host_tx_ready, host_rx_valid;
	logic [7:0] host_rx_data, port_out, port_oe_n;
	logic host_rx_ready = 1'h0;
	logic usb_configured = 1'h1;
	logic usb_suspend = 1'h0;
	logic usb_reset = 1'h0;
	logic txd, rxd, rts_n, rs485_driver_enable, line_pulldown, irq;
	logic power_switch_enable_n;
	logic cts_n = 1'h0;
	logic [7:0] port_in = 8'ha5;
	logic loop_en = 1'h0; // line model: loopback or idle
	int n_errors = 0;
	int cmp_count = 0;
	int i, k, w;
	logic [31:0] v; // last word read
	logic [31:0] fmt [6] = '{32'h0, 32'h6, 32'h8, 32'hd, 32'h10, 32'h1};
	logic [7:0] chr [6] = '{8'h41, 8'h52, 8'h63, 8'h35, 8'h7e, 8'h2a};
	logic [7:0] bbv [4] = '{8'h3c, 8'hc3, 8'h5a, 8'h96};
	ubb_top DUT (.*);
	ubb_line_model u_line (.*);
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////
	// counts, then the verdict; the only place the run ends
	task automatic end_sim;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h want %h", $time, got, exp);
		end
	endtask
	// a bound ran out: counted as a mismatch
	task automatic tmo;
		n_errors++;
		$display("Error at %0t: wait ran out", $time);
		end_sim();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// data is taken mid cycle after the read, where it stands
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask
	task automatic send(input logic [7:0] d);
		int n;
		@(posedge ref_clk);
		host_tx_data <= d;
		host_tx_valid <= 1'h1;
		for (n = 0; n < 5000; n++) begin
			@(posedge ref_clk);
			if (host_tx_ready === 1'h1) break;
		end
		if (n == 5000) tmo();
		host_tx_valid <= 1'h0;
	endtask
	// w returns the cycles spent waiting
	task automatic wait_txd(input logic lv, input int lim);
		for (w = 0; w < lim && txd !== lv; w++)
			@(negedge ref_clk);
		if (w == lim) tmo();
	endtask
	task automatic wait_de;
		for (w = 0; w < 3000 && rs485_driver_enable !== 1'h0; w++)
			@(negedge ref_clk);
		if (w == 3000) tmo();
	endtask
	// k counts low line cycles over a quiet spell
	task automatic quiet(input int n);
		k = 0;
		repeat (n) begin
			@(negedge ref_clk);
			if (txd === 1'h0) k++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(negedge ref_clk);
		check(port_oe_n, 8'hff);
		check(txd, 1'h1);
		check(irq, 1'h0);
		// defaults, the zero clamp and an unmapped place
		rd(4'h0);
		check(v, 32'h138);
		rd(4'h2);
		check(v, 32'h10);
		rd(4'h8);
		check(v, 32'h0);
		wr(4'h2, 32'h0);
		rd(4'h2);
		check(v, 32'h1);
		wr(4'h2, 32'hff);
		rd(4'h2);
		check(v, 32'hff);
		// nine low bits of a zero byte at every eighth, whole 0..2
		for (i = 0; i < 24; i++) begin
			wr(4'h0, {15'h0, i[2:0], 12'h0, i[4:3]});
			k = (i < 8) ? 300 : (i < 16) ? 450 :
				9 * (256 + 16 * (i % 8)) * 100 / 384;
			send(8'h00);
			wait_txd(1'h0, 3000);
			wait_txd(1'h1, 2000);
			check(w >= k - 6 && w <= k + 6, 1'h1);
			wait_de();
		end
		// each parity, two stop bits and 7-bit data, looped back
		loop_en <= 1'h1;
		wr(4'h0, 32'h0);
		for (i = 0; i < 6; i++) begin
			wr(4'h1, fmt[i]);
			wr(4'h3, {24'h0, chr[i]});
			send(chr[i]);
			for (w = 0; w < 3000 && host_rx_valid !== 1'h1; w++)
				@(negedge ref_clk);
			if (w == 3000) tmo();
			check(host_rx_data, chr[i]);
			@(posedge ref_clk);
			host_rx_ready <= 1'h1;
			@(posedge ref_clk);
			host_rx_ready <= 1'h0;
			rd(4'h5);
			check(v, 32'h1);
			wr(4'h5, 32'hf);
		end
		// break: line low, driver on, sticky status and masked irq
		wr(4'h0, 32'h2);
		wr(4'h6, 32'h2);
		wr(4'h1, 32'h80);
		repeat (40) @(negedge ref_clk);
		check({txd, rs485_driver_enable}, 2'h1);
		for (w = 0; w < 3000 && irq !== 1'h1; w++)
			@(negedge ref_clk);
		if (w == 3000) tmo();
		wr(4'h1, 32'h0);
		wait_de();
		check(txd, 1'h1);
		rd(4'h5);
		check(v, 32'h2);
		wr(4'h6, 32'h0);
		@(negedge ref_clk);
		check(irq, 1'h0);
		wr(4'h6, 32'h2);
		@(negedge ref_clk);
		check(irq, 1'h1);
		wr(4'h5, 32'h2);
		@(negedge ref_clk);
		check(irq, 1'h0);
		// stop character looped back halts the sender
		wr(4'h1, 32'h40);
		send(ubb_pkg::XOFF_CHAR);
		wait_txd(1'h0, 3000);
		wait_de();
		send(8'h41);
		quiet(400);
		check(k, 0);
		wr(4'h1, 32'h0);
		wait_txd(1'h0, 3000);
		wait_de();
		// hardware handshake holds the start bit back
		loop_en <= 1'h0;
		wr(4'h1, 32'h20);
		@(negedge ref_clk);
		check(rts_n, 1'h0);
		@(posedge ref_clk);
		cts_n <= 1'h1;
		send(8'h55);
		quiet(400);
		check(k, 0);
		@(posedge ref_clk);
		cts_n <= 1'h0;
		wait_txd(1'h0, 300);
		wait_de();
		// parallel port: one byte per tick, each held in between
		wr(4'h1, 32'h0);
		rd(4'h7);
		check(v[7:0], 8'ha5);
		wr(4'h4, 32'hff01);
		@(negedge ref_clk);
		check(port_oe_n, 8'h00);
		fork
			for (i = 0; i < 4; i++)
				send(bbv[i]);
			for (k = 0; k < 4; k++) begin
				for (w = 0; w < 500 && port_out !== bbv[k]; w++)
					@(negedge ref_clk);
				if (w == 500) tmo();
				check(k == 0 || (w >= 3 && w <= 6), 1'h1);
			end
		join
		wr(4'h4, 32'h0f01);
		@(negedge ref_clk);
		check(port_oe_n, 8'hf0);
		wr(4'h4, 32'h0);
		@(negedge ref_clk);
		check(port_oe_n, 8'hff);
		// every usb state, pulldown option on, then off
		wr(4'h1, 32'h100);
		for (i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			{usb_reset, usb_suspend, usb_configured} <= i[2:0];
			repeat (4) @(negedge ref_clk);
			k = (i == 1) ? 0 : 1;
			check(power_switch_enable_n, k[0]);
			check(line_pulldown, k[0]);
		end
		wr(4'h1, 32'h0);
		@(negedge ref_clk);
		check(line_pulldown, 1'h0);
		end_sim();
	end
endmodule
